// file: rtl/sar_adc_defs.svh
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// Byte register addresses, low 16 address bits
`define ADDR_RES_A_HIGH 16'hFFE0
`define ADDR_RES_A_LOW 16'hFFE1
`define ADDR_RES_B_HIGH 16'hFFE2
`define ADDR_RES_B_LOW 16'hFFE3
`define ADDR_RES_C_HIGH 16'hFFE4
`define ADDR_RES_C_LOW 16'hFFE5
`define ADDR_RES_D_HIGH 16'hFFE6
`define ADDR_RES_D_LOW 16'hFFE7
`define ADDR_CTRL_STATUS 16'hFFE8
`define ADDR_TRIG_CTRL 16'hFFE9

// Reset values
`define CTRL_STATUS_RESET 8'h00
`define TRIG_CTRL_RESET 8'h7E
`define RESULT_RESET 10'h000
`define READ_ZERO 8'h00

// Field positions
`define CSR_FLAG_BIT 7
`define TRIG_ENABLE_BIT 7
`define TRIG_SPARE_BIT 0
`define TRIG_READ_ONES 6'h3F

// Result width
`define RESULT_BITS 10

// Conversion timing in converter states (one state per clock)
`define REF_CLK_MHZ 25
`define CONV_FAST_NS 5360
`define CONV_FAST_STATES ((`CONV_FAST_NS * `REF_CLK_MHZ) / 1000)
`define CONV_SLOW_STATES 266
`define SAMPLE_FAST 14
`define SAMPLE_SLOW 26
`define BIT_FAST ((`CONV_FAST_STATES - `SAMPLE_FAST) / `RESULT_BITS)
`define BIT_SLOW ((`CONV_SLOW_STATES - `SAMPLE_SLOW) / `RESULT_BITS)

`endif

// file: rtl/adc_pkg.sv
package adc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_e;

    typedef struct packed {
        logic flag;
        logic irq_en;
        logic start;
        logic scan;
        logic fast;
        logic [2:0] channel_select_field;
    } ctrl_status_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

endpackage

// file: rtl/sar_adc_result_control.sv
`timescale 1ns/1ns
`include "sar_adc_defs.svh"

// Function
// - each finished conversion stores a 10-bit result in its channel's register.
// - result bits 9..2 sit in the high byte, bit 9 at register bit 15.
// - result bits 1..0 sit at register bits 7 and 6.
// - register bits 5..0 always read zero.
// - inputs 0/4 map to A, 1/5 to B, 2/6 to C, 3/7 to D.
// - inputs 0-3 form group 0, inputs 4-7 form group 1.
// - result registers clear on reset and on standby entry.
// - high byte read directly, low byte returned through a holding latch.
// - high byte read loads the latch; host reads high byte first.
// - single mode converts one channel once; scan cycles one to four channels.
// - end of conversion can raise an interrupt request.
// - falling external trigger edge can start conversion besides software start.
// - control/status bit 7 accepts only a zero write, clearing the flag.
// - registers decoded at FFE0-FFE7 results, FFE8 control/status, FFE9 trigger.
// - trigger control register resets to 7E.
// - fastest setting completes a conversion in 134 states, 5.36 us at 25 MHz.
// - converter can be stopped independently to save power.
// - channel field plus scan bit select single channel or group range.
// - single mode start bit self-clears; scan keeps running until cleared.
// - flag set after single conversion or full scan; cleared by read-then-write-zero.
module sar_adc_result_control #(
    parameter int unsigned SAMPLE_FAST = `SAMPLE_FAST,
    parameter int unsigned BIT_FAST = `BIT_FAST,
    parameter int unsigned SAMPLE_SLOW = `SAMPLE_SLOW,
    parameter int unsigned BIT_SLOW = `BIT_SLOW
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic standby_i,
    input wire logic module_stop_i,
    input adc_pkg::bus_req_s bus_i,
    input wire logic ext_trigger_n_i,
    input wire logic comparator_i,
    output logic [7:0] rdata_o,
    output logic sample_o,
    output logic [2:0] mux_channel_o,
    output logic [9:0] dac_code_o,
    output logic conversion_done_irq_o
);
    import adc_pkg::*;

    initial begin
        if (SAMPLE_FAST < 1 || SAMPLE_FAST > 256 || SAMPLE_SLOW < 1 || SAMPLE_SLOW > 256) begin
            $error("sample length out of range");
        end
        if (BIT_FAST < 3 || BIT_FAST > 256 || BIT_SLOW < 3 || BIT_SLOW > 256) begin
            $error("bit period must cover comparator sync latency and fit the counter");
        end
    end

    function automatic logic [9:0] bit_mask(input logic [3:0] idx);
        bit_mask = 10'h001 << idx;
    endfunction

    function automatic logic [7:0] result_high(input logic [9:0] res);
        result_high = res[9:2];
    endfunction

    function automatic logic [7:0] result_low(input logic [9:0] res);
        result_low = {res[1:0], 6'h00};
    endfunction

    function automatic logic [7:0] len_minus_one(input int unsigned len);
        len_minus_one = 8'(len - 1);
    endfunction

    // Counter loads for one sample phase or one bit period
    function automatic logic [7:0] sample_period(input logic fast);
        sample_period = len_minus_one(fast ? SAMPLE_FAST : SAMPLE_SLOW);
    endfunction

    function automatic logic [7:0] bit_period(input logic fast);
        bit_period = len_minus_one(fast ? BIT_FAST : BIT_SLOW);
    endfunction

    function automatic logic [1:0] result_slot(input logic [2:0] ch);
        result_slot = ch[1:0];
    endfunction

    localparam logic [7:0] TRIG_RESET = `TRIG_CTRL_RESET;

    // Reset release synchroniser
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin synchronisers
    logic trg_meta;
    logic trg_sync;
    logic trg_prev;
    logic cmp_meta;
    logic cmp_sync;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            trg_meta <= 1'b1;
            trg_sync <= 1'b1;
            trg_prev <= 1'b1;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else if (clk_en_i) begin
            trg_meta <= ext_trigger_n_i;
            trg_sync <= trg_meta;
            trg_prev <= trg_sync;
            cmp_meta <= comparator_i;
            cmp_sync <= cmp_meta;
        end
    end

    // Converter and register state
    conv_state_e state;
    conv_state_e next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [9:0] approx;
    logic [9:0] next_approx;
    logic [2:0] cur_ch;
    logic [2:0] next_cur_ch;
    ctrl_status_s csr;
    ctrl_status_s next_csr;
    logic trig_en;
    logic next_trig_en;
    logic trig_spare;
    logic next_trig_spare;
    logic [9:0] results [4];
    logic [9:0] next_results [4];
    logic [7:0] low_latch;
    logic [7:0] next_low_latch;
    logic flag_armed;
    logic next_flag_armed;
    logic [7:0] next_rdata;
    logic next_sample;
    logic [2:0] next_mux_channel;
    logic [9:0] next_dac_code;
    logic next_irq;

    always_comb begin
        logic [9:0] trial;
        logic [9:0] kept;
        logic [2:0] group_base;
        trial = approx | bit_mask(bit_idx);
        kept = cmp_sync ? trial : approx;
        group_base = {csr.channel_select_field[2], 2'b00};
        next_state = state;
        next_cnt = cnt;
        next_bit_idx = bit_idx;
        next_approx = approx;
        next_cur_ch = cur_ch;
        next_csr = csr;
        next_trig_en = trig_en;
        next_trig_spare = trig_spare;
        next_results = results;
        next_low_latch = low_latch;
        next_flag_armed = flag_armed;
        next_rdata = rdata_o;

        // Register reads
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                `ADDR_RES_A_HIGH, `ADDR_RES_B_HIGH, `ADDR_RES_C_HIGH, `ADDR_RES_D_HIGH: begin
                    next_rdata = result_high(results[bus_i.addr[2:1]]);
                    next_low_latch = result_low(results[bus_i.addr[2:1]]);
                end
                `ADDR_RES_A_LOW, `ADDR_RES_B_LOW, `ADDR_RES_C_LOW, `ADDR_RES_D_LOW: begin
                    next_rdata = low_latch;
                end
                `ADDR_CTRL_STATUS: begin
                    next_rdata = csr;
                    if (csr.flag) begin
                        next_flag_armed = 1'b1;
                    end
                end
                `ADDR_TRIG_CTRL: begin
                    next_rdata = {trig_en, `TRIG_READ_ONES, trig_spare};
                end
                default: begin
                    next_rdata = `READ_ZERO;
                end
            endcase
        end

        // Register writes
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                `ADDR_CTRL_STATUS: begin
                    next_csr.irq_en = bus_i.wdata[6];
                    next_csr.start = bus_i.wdata[5];
                    next_csr.scan = bus_i.wdata[4];
                    next_csr.fast = bus_i.wdata[3];
                    next_csr.channel_select_field = bus_i.wdata[2:0];
                    if (!bus_i.wdata[`CSR_FLAG_BIT] && flag_armed) begin
                        next_csr.flag = 1'b0;
                        next_flag_armed = 1'b0;
                    end
                end
                `ADDR_TRIG_CTRL: begin
                    next_trig_en = bus_i.wdata[`TRIG_ENABLE_BIT];
                    next_trig_spare = bus_i.wdata[`TRIG_SPARE_BIT];
                end
                default: begin
                end
            endcase
        end

        // External trigger on synchronised falling edge
        if (trig_en && trg_prev && !trg_sync && state == ST_IDLE) begin
            next_csr.start = 1'b1;
        end

        // Conversion sequencer
        unique case (state)
            ST_IDLE: begin
                if (csr.start) begin
                    next_state = ST_SAMPLE;
                    next_cur_ch = csr.scan ? group_base : csr.channel_select_field;
                    next_cnt = sample_period(csr.fast);
                end
            end
            ST_SAMPLE: begin
                if (!next_csr.start) begin
                    next_state = ST_IDLE;
                end else if (cnt == 8'h00) begin
                    next_state = ST_CONVERT;
                    next_bit_idx = 4'(`RESULT_BITS - 1);
                    next_approx = `RESULT_RESET;
                    next_cnt = bit_period(csr.fast);
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            ST_CONVERT: begin
                if (!next_csr.start) begin
                    next_state = ST_IDLE;
                end else if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else if (bit_idx != 4'h0) begin
                    next_approx = kept;
                    next_bit_idx = bit_idx - 4'h1;
                    next_cnt = bit_period(csr.fast);
                end else begin
                    next_approx = kept;
                    next_results[result_slot(cur_ch)] = kept;
                    if (csr.scan) begin
                        next_state = ST_SAMPLE;
                        next_cnt = sample_period(csr.fast);
                        if (cur_ch == csr.channel_select_field) begin
                            next_csr.flag = 1'b1;
                            next_cur_ch = group_base;
                        end else begin
                            next_cur_ch = cur_ch + 3'h1;
                        end
                    end else begin
                        next_state = ST_IDLE;
                        next_csr.start = 1'b0;
                        next_csr.flag = 1'b1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // Module stop halts the converter and clears only the start bit
        if (module_stop_i) begin
            next_state = ST_IDLE;
            next_csr.start = 1'b0;
        end

        // Standby returns the result, control/status, trigger and latch registers to reset values
        if (standby_i) begin
            next_state = ST_IDLE;
            next_csr = `CTRL_STATUS_RESET;
            next_trig_en = TRIG_RESET[`TRIG_ENABLE_BIT];
            next_trig_spare = TRIG_RESET[`TRIG_SPARE_BIT];
            next_flag_armed = 1'b0;
            next_low_latch = `READ_ZERO;
            for (int i = 0; i < 4; i++) begin
                next_results[i] = `RESULT_RESET;
            end
        end

        next_sample = (next_state == ST_SAMPLE);
        next_mux_channel = next_cur_ch;
        next_dac_code = (next_state == ST_CONVERT) ? (next_approx | bit_mask(next_bit_idx))
                                                  : `RESULT_RESET;
        next_irq = next_csr.flag && next_csr.irq_en;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            bit_idx <= 4'h0;
            approx <= `RESULT_RESET;
            cur_ch <= 3'h0;
            csr <= `CTRL_STATUS_RESET;
            trig_en <= TRIG_RESET[`TRIG_ENABLE_BIT];
            trig_spare <= TRIG_RESET[`TRIG_SPARE_BIT];
            for (int i = 0; i < 4; i++) begin
                results[i] <= `RESULT_RESET;
            end
            low_latch <= `READ_ZERO;
            flag_armed <= 1'b0;
            rdata_o <= `READ_ZERO;
            sample_o <= 1'b0;
            mux_channel_o <= 3'h0;
            dac_code_o <= `RESULT_RESET;
            conversion_done_irq_o <= 1'b0;
        end else if (clk_en_i) begin
            state <= next_state;
            cnt <= next_cnt;
            bit_idx <= next_bit_idx;
            approx <= next_approx;
            cur_ch <= next_cur_ch;
            csr <= next_csr;
            trig_en <= next_trig_en;
            trig_spare <= next_trig_spare;
            results <= next_results;
            low_latch <= next_low_latch;
            flag_armed <= next_flag_armed;
            rdata_o <= next_rdata;
            sample_o <= next_sample;
            mux_channel_o <= next_mux_channel;
            dac_code_o <= next_dac_code;
            conversion_done_irq_o <= next_irq;
        end
    end

endmodule

// file: verif/sar_adc_sva.sv
`timescale 1ns/1ns
module sar_adc_sva #(
    parameter int unsigned SAMPLE_FAST = 3,
    parameter int unsigned BIT_FAST = 4,
    parameter int unsigned SAMPLE_SLOW = 4,
    parameter int unsigned BIT_SLOW = 5
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic standby_i,
    input wire logic module_stop_i,
    input adc_pkg::bus_req_s bus_i,
    input wire logic ext_trigger_n_i,
    input wire logic comparator_i,
    input wire logic [7:0] rdata_o,
    input wire logic sample_o,
    input wire logic [2:0] mux_channel_o,
    input wire logic [9:0] dac_code_o,
    input wire logic conversion_done_irq_o
);
    import adc_pkg::*;
    localparam int SPAN = SAMPLE_SLOW - SAMPLE_FAST + 1;
    logic rd;
    logic wr_cs;
    logic [7:0] csr_w;
    logic [7:0] next_csr_w;
    assign rd = bus_i.rd && clk_en_i;
    assign wr_cs = bus_i.wr && clk_en_i && bus_i.addr == 16'hFFE8;
    // Last value written to control/status
    always_comb begin
        next_csr_w = wr_cs ? bus_i.wdata : csr_w;
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            csr_w <= 8'h00;
        end else begin
            csr_w <= next_csr_w;
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    low_byte_zero_a: assert property (
        rd && bus_i.addr[15:3] == 13'h1FFC && bus_i.addr[0] |=> rdata_o[5:0] == 6'h00)
        else $error("low byte reserved bits set");
    unmapped_read_a: assert property (
        rd && (bus_i.addr < 16'hFFE0 || bus_i.addr > 16'hFFE9) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    trig_ones_a: assert property (
        rd && bus_i.addr == 16'hFFE9 |=> rdata_o[6:1] == 6'h3F)
        else $error("trigger reserved bits not one");
    rdata_hold_a: assert property (
        !rd && !standby_i && !$past(standby_i) |=> $stable(rdata_o))
        else $error("read data moved without read");
    sample_len_a: assert property (
        $rose(sample_o) && !module_stop_i && !standby_i |-> sample_o[*3] ##[1:SPAN] !sample_o)
        else $error("sample phase length wrong");
    msb_trial_a: assert property (
        $fell(sample_o) && !$past(module_stop_i) && !$past(standby_i) |-> dac_code_o == 10'h200)
        else $error("first trial not msb");
    dac_idle_a: assert property (sample_o |-> dac_code_o == 10'h000)
        else $error("trial code during sample");
    mux_select_a: assert property (
        $rose(sample_o) && !csr_w[4] |-> mux_channel_o == csr_w[2:0])
        else $error("single mode channel wrong");
    irq_cause_a: assert property (
        $rose(conversion_done_irq_o) |-> $past(dac_code_o) != 10'h000 || $past(bus_i.wr)
            || $past(bus_i.wr, 2))
        else $error("interrupt without cause");
    irq_mask_a: assert property (
        wr_cs && !bus_i.wdata[6] |-> ##[1:2] !conversion_done_irq_o)
        else $error("masked interrupt stays high");
    cover property ($rose(conversion_done_irq_o));
    cover property ($fell(sample_o) && csr_w[4]);
    cover property (rd && bus_i.addr == 16'hFFE7);
endmodule

bind sar_adc_result_control sar_adc_sva #(.SAMPLE_FAST(SAMPLE_FAST), .BIT_FAST(BIT_FAST),
    .SAMPLE_SLOW(SAMPLE_SLOW), .BIT_SLOW(BIT_SLOW)) u_sva (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .clk_en_i(clk_en_i), .standby_i(standby_i),
    .module_stop_i(module_stop_i), .bus_i(bus_i), .ext_trigger_n_i(ext_trigger_n_i),
    .comparator_i(comparator_i), .rdata_o(rdata_o), .sample_o(sample_o),
    .mux_channel_o(mux_channel_o), .dac_code_o(dac_code_o),
    .conversion_done_irq_o(conversion_done_irq_o));

// file: verif/analog_front_model.sv
`timescale 1ns/1ns
module analog_front_model (
    input wire logic [2:0] mux_channel_i,
    input wire logic [9:0] dac_code_i,
    input wire logic [79:0] levels_i,
    output logic comparator_o
);
    // Ideal comparator, high while the selected input reaches the trial code
    assign comparator_o = levels_i[mux_channel_i*10+:10] >= dac_code_i;
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    import adc_pkg::*;
    localparam int unsigned SF = 3;
    localparam int unsigned BF = 4;
    localparam logic [15:0] CS = 16'hFFE8;
    logic clk, nrst, stby, stop, trig_n, cmp, irq, smp;
    logic [7:0] rdata;
    logic [2:0] mux;
    logic [9:0] dac, v;
    logic [79:0] levels;
    bus_req_s bus;
    int errors, total_checks, n;
    sar_adc_result_control #(.SAMPLE_FAST(SF), .BIT_FAST(BF), .SAMPLE_SLOW(4),
        .BIT_SLOW(5)) dut (.core_clk_i(clk), .nrst_i(nrst), .clk_en_i(1'b1),
        .standby_i(stby), .module_stop_i(stop), .bus_i(bus), .ext_trigger_n_i(trig_n),
        .comparator_i(cmp), .rdata_o(rdata), .sample_o(smp), .mux_channel_o(mux),
        .dac_code_o(dac), .conversion_done_irq_o(irq));
    analog_front_model afe (.mux_channel_i(mux), .dac_code_i(dac), .levels_i(levels),
        .comparator_o(cmp));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [9:0] lvl(input int c, input int s);
        return 10'h04D + 10'(c) * 10'h07B + 10'(s) * 10'h12D;
    endfunction
    task automatic set_levels(input int s);
        for (int c = 0; c < 8; c++) levels[c*10+:10] = lvl(c, s);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(posedge clk);
        #1;
        bus.wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        bus.rd = 1'b1;
        bus.addr = a;
        @(posedge clk);
        #1;
        bus.rd = 1'b0;
        d = rdata;
    endtask
    task automatic fail(input string m);
        errors++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        total_checks++;
        if (d !== e) fail($sformatf("read %h got %h want %h", a, d, e));
    endtask
    task automatic wait_irq();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq !== 1'b1 && n < 400);
        if (irq !== 1'b1) fail("no interrupt within limit");
    endtask
    task automatic wait_flag();
        logic [7:0] d;
        n = 0;
        do begin
            rd(CS, d);
            n++;
        end while (d[7] !== 1'b1 && n < 200);
        if (d[7] !== 1'b1) fail("done flag not set within limit");
    endtask
    task automatic defaults();
        wr(16'hFFE0, 8'hFF);
        wr(16'hFFEA, 8'hFF);
        wr(CS, 8'h80);
        for (int a = 0; a < 10; a++) chk(16'hFFE0 + 16'(a), a == 9 ? 8'h7E : 8'h00);
        chk(16'hFFEA, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        fail("watchdog expired");
        report_and_stop();
    end
    initial begin
        nrst = 1'b0;
        stby = 1'b0;
        stop = 1'b0;
        trig_n = 1'b1;
        bus = '0;
        errors = 0;
        total_checks = 0;
        set_levels(0);
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        defaults();
        $display("test reset_values done");
        for (int c = 0; c < 8; c++) begin
            wr(CS, 8'h68 | 8'(c));
            wait_irq();
            total_checks++;
            if (n != 1 + SF + 10 * BF) fail("conversion time");
            v = lvl(c, 0);
            chk(CS, 8'hC8 | 8'(c));
            chk(16'hFFE0 + 16'(2 * (c % 4)), v[9:2]);
            chk(16'hFFE1 + 16'(2 * (c % 4)), {v[1:0], 6'h00});
            wr(CS, 8'h48 | 8'(c));
        end
        v = lvl(4, 0);
        chk(16'hFFE0, v[9:2]);
        chk(16'hFFE7, {v[1:0], 6'h00});
        $display("test single_channels done");
        wr(CS, 8'h69);
        wait_irq();
        wr(CS, 8'h49);
        chk(CS, 8'hC9);
        wr(CS, 8'hC9);
        chk(CS, 8'hC9);
        wr(CS, 8'h49);
        chk(CS, 8'h49);
        total_checks++;
        if (irq !== 1'b0) fail("interrupt still high");
        $display("test done_flag done");
        set_levels(1);
        wr(CS, 8'h3E);
        wait_flag();
        repeat (100) @(posedge clk);
        chk(CS, 8'hBE);
        wr(CS, 8'h1E);
        repeat (60) @(posedge clk);
        for (int c = 4; c < 7; c++) begin
            v = lvl(c, 1);
            chk(16'hFFE0 + 16'(2 * (c - 4)), v[9:2]);
        end
        v = lvl(7, 0);
        chk(16'hFFE6, v[9:2]);
        chk(CS, 8'h1E);
        $display("test scan done");
        wr(CS, 8'h0A);
        trig_n = 1'b0;
        repeat (60) @(posedge clk);
        chk(CS, 8'h0A);
        trig_n = 1'b1;
        wr(16'hFFE9, 8'h80);
        chk(16'hFFE9, 8'hFE);
        trig_n = 1'b0;
        wait_flag();
        chk(CS, 8'h8A);
        v = lvl(2, 1);
        chk(16'hFFE4, v[9:2]);
        trig_n = 1'b1;
        $display("test trigger done");
        wr(CS, 8'h23);
        repeat (20) @(posedge clk);
        #1;
        stop = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        stop = 1'b0;
        chk(CS, 8'h03);
        v = lvl(7, 0);
        chk(16'hFFE6, v[9:2]);
        stby = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        stby = 1'b0;
        defaults();
        $display("test stop_standby done");
        report_and_stop();
    end
endmodule
